// *** shared/fpsc_regs.vh ***
// Purpose: Constants for the floating point pipeline status and control unit
// Assumes: Included by the design files under verilog/
// Notes on behaviour
// - Pipe bypass low: ALU and multiplier pipeline registers clock; high: flowthrough.
// - Result bypass low: status, product and sum registers clock; high: flowthrough.
// - Reset clears state, status, exception disable; pipeline lost; data registers kept.
// - Two rounding select inputs decode to one of four rounding modes.
// - Rounding increment flag high when rounding grew the mantissa magnitude.
// - Half select low gives low half on Y, high gives high half; single ignores.
// - C register loads from ALU when source select low, multiplier when high.
// - Equal flag: operands equal during compare, otherwise Y result is zero.
// - Greater flag high when compare finds A greater than B.
// - Chain exception flag; bit six low means multiplier source, high means ALU.
// - Tiny operand flag for denormal multiplier input, with port flags alongside.
// - Tiny result flag for denormal ALU or wrapped multiplier; flush forces zero.
// - Zero divisor flag whenever an operation attempts division by zero.
// - Exception summary is OR of exceptions enabled in exception disable register.
// - Not exact flag whenever the delivered result lost precision.
// - Unbounded flag high whenever the output value is infinity.
// - Sign flag high whenever the result is negative.
// - Invalid flag for invalid operation or NaN operand into multiplier or ALU.
// - Exponent too large flag when result exceeds largest format value.
// - Exception origin low for ALU cause, high for multiplier cause.
// - Port flags mark NaN or denormal input: upper bit A, lower bit B.
// - Too small flag for inexact tiny result; incomparable flag for NaN compare.
// - Flush high zeroes denormals suddenly; low keeps gradual underflow.
// - Status pins driven only while active-low status output enable is low.
`ifndef FPSC_REGS_VH
`define FPSC_REGS_VH
// Register offsets on the plain register port
`define FPSC_ADDR_W          4
`define FPSC_OFS_EXC_DISABLE 4'h0
`define FPSC_OFS_STATUS      4'h1
`define FPSC_OFS_ROUND_MODE  4'h2
`define FPSC_EXC_DIS_RESET   7'h00
// Condition vector from each arithmetic unit
`define FPSC_COND_W     15
`define FPSC_C_INVALID  0
`define FPSC_C_DIVZERO  1
`define FPSC_C_OVER     2
`define FPSC_C_UNDER    3
`define FPSC_C_INEXACT  4
`define FPSC_C_TINY     5
`define FPSC_C_TINY_OPERAND_MULTIPLIER_FLAG    6
`define FPSC_C_INF      7
`define FPSC_C_NEG      8
`define FPSC_C_EQUAL    9
`define FPSC_C_GREATER  10
`define FPSC_C_INCOMPARABLE_OPERANDS_FLAG    11
`define FPSC_C_RNDINC   12
`define FPSC_C_PORTB    13
`define FPSC_C_PORTA    14
`define FPSC_EXC_W      7
// Status register layout, conditions plus these
`define FPSC_STAT_W     18
`define FPSC_S_CHAIN    15
`define FPSC_S_ORIGIN   16
`define FPSC_S_COMPARE  17
`define FPSC_STAT_RESET 18'h00000
// Rounding modes, one-hot to the datapath
`define FPSC_RND_NEAREST 2'h0
`define FPSC_RND_ZERO    2'h1
`define FPSC_RND_PLUS    2'h2
`define FPSC_RND_MINUS   2'h3
`endif

// *** verilog/fpsc_stage.v ***
// Purpose: One pipeline register with flowthrough bypass
// Assumes: Synchronous active-low reset, single clock
// Notes: CLEARS selects whether reset empties the register
`timescale 1ns/1ns
module fpsc_stage
#(
   parameter WIDTH  = 8,
   parameter CLEARS = 1
)
(
   input  wire             sys_clk,
   input  wire             rstn,
   input  wire             bypass,
   input  wire [WIDTH-1:0] dataIn,
   output wire [WIDTH-1:0] dataOut
);
   reg [WIDTH-1:0] stage_reg;
   always @(posedge sys_clk)
   begin
      if (!rstn && (CLEARS != 0))
         stage_reg <= {WIDTH{1'h0}};
      else
         stage_reg <= dataIn;
   end
   // No edge waited for in flowthrough, so the path is combinational
   assign dataOut = bypass ? dataIn : stage_reg;
endmodule // fpsc_stage

// *** verilog/fpsc_unit.v ***
// Purpose: Pipeline control and status reporting for a 64-bit FP/integer processor
// Assumes: Controller and datapath run on sys_clk; condition vectors come from the units
// Notes: Status pins are driven out with a shared enable; register port reads lag one cycle
`timescale 1ns/1ns
`include "fpsc_regs.vh"
module fpsc_unit
(
   input  wire                     sys_clk,
   input  wire                     rstn,
   input  wire                     aluMultiplierPipeBypass,
   input  wire                     resultStageBypass,
   input  wire [1:0]               roundingModeSelect,
   input  wire                     resultHalfSelect,
   input  wire                     cRegisterSourceSelect,
   input  wire                     cRegisterWriteN,
   input  wire                     instructionBitSix,
   input  wire                     flushToZeroSelect,
   input  wire                     statusOutputEnableN,
   input  wire                     chainedOp,
   input  wire                     compareOp,
   input  wire                     singlePrecision,
   input  wire                     resultFromMultiplier,
   input  wire [63:0]              aluResult,
   input  wire [63:0]              mulResult,
   input  wire [`FPSC_COND_W-1:0]  aluCond,
   input  wire [`FPSC_COND_W-1:0]  mulCond,
   input  wire [`FPSC_ADDR_W-1:0]  regAddr,
   input  wire [31:0]              regWrData,
   input  wire                     regWrStb,
   input  wire                     regRdStb,
   output reg  [31:0]              regRdData,
   output wire [3:0]               roundModeOneHot,
   output wire [31:0]              yBus,
   output wire [63:0]              cRegOut,
   output wire                     statusOe,
   output wire                     roundingIncrementFlag,
   output wire                     equalOrZeroFlag,
   output wire                     aGreaterFlag,
   output wire                     chainExceptionFlag,
   output wire                     tinyOperandMultiplierFlag,
   output wire                     tinyResultFlag,
   output wire                     zeroDivisorFlag,
   output wire                     exceptionSummaryFlag,
   output wire                     notExactFlag,
   output wire                     resultIsUnboundedFlag,
   output wire                     signFlagMinus,
   output wire                     invalidOperationFlag,
   output wire                     exponentTooLargeFlag,
   output wire                     exponentTooSmallFlag,
   output wire                     exceptionOriginFlag,
   output wire [1:0]               operandPortFlags,
   output wire                     incomparableOperandsFlag
);
   localparam CTL_W   = 5;
   localparam PIPE_W  = 2 * `FPSC_COND_W + 128 + CTL_W;
   localparam RES_W   = `FPSC_STAT_W + 128;

   // Pipeline stage: conditions, raw results and per-operation control
   wire [PIPE_W-1:0]       pipeIn;
   wire [PIPE_W-1:0]       pipeOut;
   wire [`FPSC_COND_W-1:0] aluCondP;
   wire [`FPSC_COND_W-1:0] mulCondP;
   wire [63:0]             aluResP;
   wire [63:0]             mulResP;
   wire                    chainedP;
   wire                    compareP;
   wire                    sixP;
   wire                    fromMulP;
   wire                    singleP;

   assign pipeIn = {aluCond, mulCond, aluResult, mulResult,
                    chainedOp, compareOp, instructionBitSix,
                    resultFromMultiplier, singlePrecision};

   // Reset empties the pipeline so no stale conditions reach status
   fpsc_stage
   #(
      .WIDTH  (PIPE_W),
      .CLEARS (1)
   )
   pipeStage
   (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .bypass  (aluMultiplierPipeBypass),
      .dataIn  (pipeIn),
      .dataOut (pipeOut)
   );

   assign {aluCondP, mulCondP, aluResP, mulResP,
           chainedP, compareP, sixP, fromMulP, singleP} = pipeOut;

   // Exception grouping per unit
   wire aluExc;
   wire mulExc;
   assign aluExc = |aluCondP[`FPSC_EXC_W-1:0];
   assign mulExc = |mulCondP[`FPSC_EXC_W-1:0];

   // Sudden underflow zeroes tiny results before they are stored
   wire [63:0] sumFlushed;
   wire [63:0] prodFlushed;
   assign sumFlushed  = (flushToZeroSelect && aluCondP[`FPSC_C_TINY]) ?
                        64'h0000000000000000 : aluResP;
   assign prodFlushed = (flushToZeroSelect && mulCondP[`FPSC_C_TINY]) ?
                        64'h0000000000000000 : mulResP;

   // Status gathered from the unit whose result is delivered
   reg  [`FPSC_STAT_W-1:0] statNext;
   wire [`FPSC_COND_W-1:0] selCond;
   assign selCond = fromMulP ? mulCondP : aluCondP;

   always @*
   begin
      statNext = {`FPSC_STAT_W{1'h0}};
      statNext[`FPSC_C_INVALID] = selCond[`FPSC_C_INVALID];
      statNext[`FPSC_C_DIVZERO] = selCond[`FPSC_C_DIVZERO];
      statNext[`FPSC_C_OVER]    = selCond[`FPSC_C_OVER];
      statNext[`FPSC_C_UNDER]   = selCond[`FPSC_C_UNDER] &&
                                  selCond[`FPSC_C_INEXACT];
      statNext[`FPSC_C_INEXACT] = selCond[`FPSC_C_INEXACT];
      statNext[`FPSC_C_TINY]    = selCond[`FPSC_C_TINY];
      // Denormal operands are only reported for the multiplier
      statNext[`FPSC_C_TINY_OPERAND_MULTIPLIER_FLAG]   = mulCondP[`FPSC_C_TINY_OPERAND_MULTIPLIER_FLAG];
      statNext[`FPSC_C_INF]     = selCond[`FPSC_C_INF];
      statNext[`FPSC_C_NEG]     = selCond[`FPSC_C_NEG];
      statNext[`FPSC_C_EQUAL]   = selCond[`FPSC_C_EQUAL];
      statNext[`FPSC_C_GREATER] = compareP && selCond[`FPSC_C_GREATER];
      statNext[`FPSC_C_INCOMPARABLE_OPERANDS_FLAG]   = compareP && selCond[`FPSC_C_INCOMPARABLE_OPERANDS_FLAG];
      statNext[`FPSC_C_RNDINC]  = selCond[`FPSC_C_RNDINC];
      if (mulCondP[`FPSC_C_TINY_OPERAND_MULTIPLIER_FLAG])
      begin
         statNext[`FPSC_C_PORTA] = mulCondP[`FPSC_C_PORTA];
         statNext[`FPSC_C_PORTB] = mulCondP[`FPSC_C_PORTB];
      end
      else
      begin
         statNext[`FPSC_C_PORTA] = selCond[`FPSC_C_PORTA];
         statNext[`FPSC_C_PORTB] = selCond[`FPSC_C_PORTB];
      end
      statNext[`FPSC_S_CHAIN]   = chainedP && (sixP ? aluExc : mulExc);
      // The ALU wins when both units fault in the same cycle
      statNext[`FPSC_S_ORIGIN]  = mulExc && !aluExc;
      statNext[`FPSC_S_COMPARE] = compareP;
   end

   // Result stage: status cleared by reset, product and sum kept
   wire [`FPSC_STAT_W-1:0] statQ;
   wire [63:0]             sumQ;
   wire [63:0]             prodQ;
   wire                    singleQ;
   wire                    fromMulQ;
   reg                     singleQ_reg;
   reg                     fromMulQ_reg;

   fpsc_stage
   #(
      .WIDTH  (`FPSC_STAT_W),
      .CLEARS (1)
   )
   statusStage
   (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .bypass  (resultStageBypass),
      .dataIn  (statNext),
      .dataOut (statQ)
   );

   fpsc_stage
   #(
      .WIDTH  (128),
      .CLEARS (0)
   )
   resultStage
   (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .bypass  (resultStageBypass),
      .dataIn  ({prodFlushed, sumFlushed}),
      .dataOut ({prodQ, sumQ})
   );

   // Format and source travel with the stored result
   always @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         singleQ_reg  <= 1'h0;
         fromMulQ_reg <= 1'h0;
      end
      else
      begin
         singleQ_reg  <= singleP;
         fromMulQ_reg <= fromMulP;
      end
   end
   assign singleQ  = resultStageBypass ? singleP : singleQ_reg;
   assign fromMulQ = resultStageBypass ? fromMulP : fromMulQ_reg;

   // Y bus half selection
   wire [63:0] resultSel;
   wire        yZero;
   assign resultSel = fromMulQ ? prodQ : sumQ;
   assign yBus      = (singleQ || !resultHalfSelect) ?
                      resultSel[31:0] : resultSel[63:32];
   assign yZero     = (yBus == 32'h00000000);

   // C register, a data register that reset leaves alone
   reg  [63:0] cData_reg;
   wire [63:0] cData_next;
   assign cData_next = cRegisterSourceSelect ? prodQ : sumQ;
   always @(posedge sys_clk)
   begin
      if (!cRegisterWriteN)
         cData_reg <= cData_next;
   end
   assign cRegOut = cData_reg;

   // Rounding mode decode
   reg [3:0] roundOneHot;
   always @*
   begin
      case (roundingModeSelect)
         `FPSC_RND_NEAREST : roundOneHot = 4'h1;
         `FPSC_RND_ZERO    : roundOneHot = 4'h2;
         `FPSC_RND_PLUS    : roundOneHot = 4'h4;
         `FPSC_RND_MINUS   : roundOneHot = 4'h8;
         default           : roundOneHot = 4'h1;
      endcase
   end
   assign roundModeOneHot = roundOneHot;

   // Exception disable register, a set bit masks that exception
   reg  [`FPSC_EXC_W-1:0] excDisable_reg;
   reg  [`FPSC_EXC_W-1:0] excDisable_next;
   wire [`FPSC_EXC_W-1:0] excEnabled;
   always @*
   begin
      excDisable_next = excDisable_reg;
      if (regWrStb && (regAddr == `FPSC_OFS_EXC_DISABLE))
         excDisable_next = regWrData[`FPSC_EXC_W-1:0];
   end
   always @(posedge sys_clk)
   begin
      if (!rstn)
         excDisable_reg <= `FPSC_EXC_DIS_RESET;
      else
         excDisable_reg <= excDisable_next;
   end
   // Mask is applied live so a new setting acts without a pipeline flush
   assign excEnabled = statQ[`FPSC_EXC_W-1:0] & ~excDisable_reg;

   // Final status values before the output enables
   wire equalOrZero;
   wire summary;
   assign equalOrZero = statQ[`FPSC_S_COMPARE] ?
                        statQ[`FPSC_C_EQUAL] : yZero;
   assign summary     = |excEnabled;

   // Register read port, one cycle of latency, unmapped reads zero
   reg [31:0] rdMux;
   always @*
   begin
      case (regAddr)
         `FPSC_OFS_EXC_DISABLE : rdMux = {25'h0000000, excDisable_reg};
         `FPSC_OFS_STATUS      : rdMux = {14'h0000, statQ};
         `FPSC_OFS_ROUND_MODE  : rdMux = {30'h00000000, roundingModeSelect};
         default               : rdMux = 32'h00000000;
      endcase
   end
   always @(posedge sys_clk)
   begin
      if (!rstn)
         regRdData <= 32'h00000000;
      else if (regRdStb)
         regRdData <= rdMux;
      else
         regRdData <= 32'h00000000;
   end

   // Status pins; out values are held low while the pins float
   wire statusDrive;
   assign statusDrive = !statusOutputEnableN;
   assign statusOe    = statusDrive;

   assign roundingIncrementFlag     = statusDrive && statQ[`FPSC_C_RNDINC];
   assign equalOrZeroFlag           = statusDrive && equalOrZero;
   assign aGreaterFlag              = statusDrive && statQ[`FPSC_C_GREATER];
   assign chainExceptionFlag        = statusDrive && statQ[`FPSC_S_CHAIN];
   assign tinyOperandMultiplierFlag = statusDrive && statQ[`FPSC_C_TINY_OPERAND_MULTIPLIER_FLAG];
   assign tinyResultFlag            = statusDrive && statQ[`FPSC_C_TINY];
   assign zeroDivisorFlag           = statusDrive && statQ[`FPSC_C_DIVZERO];
   assign exceptionSummaryFlag      = statusDrive && summary;
   assign notExactFlag              = statusDrive && statQ[`FPSC_C_INEXACT];
   assign resultIsUnboundedFlag     = statusDrive && statQ[`FPSC_C_INF];
   assign signFlagMinus             = statusDrive && statQ[`FPSC_C_NEG];
   assign invalidOperationFlag      = statusDrive && statQ[`FPSC_C_INVALID];
   assign exponentTooLargeFlag      = statusDrive && statQ[`FPSC_C_OVER];
   assign exponentTooSmallFlag      = statusDrive && statQ[`FPSC_C_UNDER];
   assign exceptionOriginFlag       = statusDrive && statQ[`FPSC_S_ORIGIN];
   assign operandPortFlags          = statusDrive ?
                                      {statQ[`FPSC_C_PORTA], statQ[`FPSC_C_PORTB]} :
                                      2'h0;
   assign incomparableOperandsFlag  = statusDrive && statQ[`FPSC_C_INCOMPARABLE_OPERANDS_FLAG];
endmodule // fpsc_unit

// *** verification/fpsc_unit_sva.sv ***
// Purpose: Port-level checks of the pipeline status unit
// Assumes: One clock, synchronous active-low reset
// Notes: Mask mirror follows register port writes, so no internal probe is needed
`timescale 1ns/1ns
module fpsc_unit_sva
(
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic        aluMultiplierPipeBypass,
   input wire logic        resultStageBypass,
   input wire logic [1:0]  roundingModeSelect,
   input wire logic        statusOutputEnableN,
   input wire logic        resultFromMultiplier,
   input wire logic [14:0] aluCond,
   input wire logic [14:0] mulCond,
   input wire logic [3:0]  regAddr,
   input wire logic [31:0] regWrData,
   input wire logic        regWrStb,
   input wire logic        regRdStb,
   input wire logic [31:0] regRdData,
   input wire logic [3:0]  roundModeOneHot,
   input wire logic        statusOe,
   input wire logic        zeroDivisorFlag,
   input wire logic        exceptionSummaryFlag,
   input wire logic        invalidOperationFlag,
   input wire logic        tinyOperandMultiplierFlag,
   input wire logic [1:0]  operandPortFlags
);
   logic [6:0]  disQ;
   wire  [14:0] sel  = resultFromMultiplier ? mulCond : aluCond;
   wire  [6:0]  exc  = {mulCond[6], sel[5:4], sel[3] & sel[4], sel[2:0]};
   wire         flow = aluMultiplierPipeBypass && resultStageBypass;
   always @(posedge sys_clk)
   begin
      if (!rstn)
         disQ <= 7'h00;
      else if (regWrStb && regAddr == 4'h0)
         disQ <= regWrData[6:0];
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   AST_OE: assert property (statusOe == !statusOutputEnableN)
      else $error("status enable does not follow its pin");
   AST_GATE: assert property (!statusOe |->
      !(zeroDivisorFlag || exceptionSummaryFlag || invalidOperationFlag))
      else $error("status driven while disabled");
   AST_RND: assert property (roundModeOneHot == (4'h1 << roundingModeSelect))
      else $error("rounding decode wrong");
   AST_RDMODE: assert property (regRdStb && regAddr == 4'h2 |=>
      regRdData == {30'h0, $past(roundingModeSelect)})
      else $error("rounding mirror read wrong");
   AST_LAT2: assert property ((!aluMultiplierPipeBypass && !resultStageBypass
      && !resultFromMultiplier && aluCond[1]) ##1 (!aluMultiplierPipeBypass
      && !resultStageBypass) [*2] |-> !statusOe || zeroDivisorFlag)
      else $error("divide flag missing two cycles on");
   AST_LAT1: assert property ((aluMultiplierPipeBypass && !resultStageBypass) [*2]
      |-> invalidOperationFlag == (statusOe && $past(sel[0])))
      else $error("invalid flag wrong one cycle on");
   AST_FLOW: assert property (flow |-> zeroDivisorFlag == (statusOe && sel[1]))
      else $error("flowthrough divide flag wrong");
   AST_SUM: assert property (flow |->
      exceptionSummaryFlag == (statusOe && |(exc & ~disQ)))
      else $error("exception summary wrong");
   AST_TINY_OPERAND_MULTIPLIER_FLAG: assert property (flow |->
      {tinyOperandMultiplierFlag, operandPortFlags} == (statusOe ?
      {mulCond[6], mulCond[6] ? mulCond[14:13] : sel[14:13]} : 3'h0))
      else $error("denormal input flags wrong");
endmodule // fpsc_unit_sva

// *** verification/fpsc_ctrl_model.sv ***
// Purpose: Controller model issuing operations and enabling status drive
// Assumes: put is called just after a rising edge
// Notes: Values move only through put, so they are stable over whole cycles
`timescale 1ns/1ns
module fpsc_ctrl_model
(
   output logic        statusOutputEnableN,
   output logic        chainedOp,
   output logic        instructionBitSix,
   output logic        compareOp,
   output logic        resultFromMultiplier,
   output logic        singlePrecision,
   output logic [14:0] aluCond,
   output logic [14:0] mulCond,
   output logic [63:0] aluResult,
   output logic [63:0] mulResult
);
   initial put(15'h0000, 15'h0000, 7'h00);
   // ctl: single, zero result, enable off, chained, bit six, compare, multiplier
   task put(input logic [14:0] ac, input logic [14:0] mc, input logic [6:0] ctl);
   begin
      statusOutputEnableN  <= ctl[4];
      chainedOp            <= ctl[3];
      instructionBitSix    <= ctl[2];
      compareOp            <= ctl[1];
      resultFromMultiplier <= ctl[0];
      singlePrecision      <= ctl[6];
      aluCond              <= ac;
      mulCond              <= mc;
      aluResult            <= ctl[5] ? 64'h0 : 64'h123456789ABCDEF0;
      mulResult            <= 64'h0FEDCBA987654321;
   end
   endtask
endmodule // fpsc_ctrl_model

// *** verification/fpsc_unit_test.sv ***
// Purpose: Self-checking bench of the pipeline status unit
// Assumes: 25 MHz clock, controller model drives the operation inputs
// Notes: Flag table runs in full flowthrough so results show in the same cycle
`timescale 1ns/1ns
module fpsc_unit_test;
   logic sys_clk = 1'b0, rstn = 1'b0, aluMultiplierPipeBypass = 1'b0, resultStageBypass = 1'b0;
   logic resultHalfSelect = 1'b0, cRegisterSourceSelect = 1'b0, cRegisterWriteN = 1'b1;
   logic flushToZeroSelect = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0;
   logic [1:0]  roundingModeSelect = 2'h0;
   logic [3:0]  regAddr = 4'h0;
   logic [31:0] regWrData = 32'h0;
   int num_errors = 0, n_tests = 0, i, j;
   wire statusOutputEnableN, chainedOp, instructionBitSix, compareOp, resultFromMultiplier;
   wire singlePrecision, statusOe, roundingIncrementFlag, equalOrZeroFlag, aGreaterFlag;
   wire chainExceptionFlag, tinyOperandMultiplierFlag, tinyResultFlag, zeroDivisorFlag;
   wire exceptionSummaryFlag, notExactFlag, resultIsUnboundedFlag, signFlagMinus;
   wire invalidOperationFlag, exponentTooLargeFlag, exponentTooSmallFlag, exceptionOriginFlag;
   wire incomparableOperandsFlag;
   wire [1:0]  operandPortFlags;
   wire [3:0]  roundModeOneHot;
   wire [14:0] aluCond, mulCond;
   wire [31:0] regRdData, yBus;
   wire [63:0] aluResult, mulResult, cRegOut;
   wire [17:0] flags = {roundingIncrementFlag, equalOrZeroFlag, aGreaterFlag,
      chainExceptionFlag, tinyOperandMultiplierFlag, tinyResultFlag, zeroDivisorFlag,
      exceptionSummaryFlag, notExactFlag, resultIsUnboundedFlag, signFlagMinus,
      invalidOperationFlag, exponentTooLargeFlag, exponentTooSmallFlag,
      exceptionOriginFlag, operandPortFlags, incomparableOperandsFlag};
   fpsc_ctrl_model u_ctrl (.statusOutputEnableN(statusOutputEnableN), .chainedOp(chainedOp),
      .instructionBitSix(instructionBitSix), .compareOp(compareOp),
      .resultFromMultiplier(resultFromMultiplier), .singlePrecision(singlePrecision),
      .aluCond(aluCond), .mulCond(mulCond), .aluResult(aluResult), .mulResult(mulResult));
   fpsc_unit i_dut (.sys_clk(sys_clk), .rstn(rstn),
      .aluMultiplierPipeBypass(aluMultiplierPipeBypass), .resultStageBypass(resultStageBypass),
      .roundingModeSelect(roundingModeSelect), .resultHalfSelect(resultHalfSelect),
      .cRegisterSourceSelect(cRegisterSourceSelect), .cRegisterWriteN(cRegisterWriteN),
      .instructionBitSix(instructionBitSix), .flushToZeroSelect(flushToZeroSelect),
      .statusOutputEnableN(statusOutputEnableN), .chainedOp(chainedOp), .compareOp(compareOp),
      .singlePrecision(singlePrecision), .resultFromMultiplier(resultFromMultiplier),
      .aluResult(aluResult), .mulResult(mulResult), .aluCond(aluCond), .mulCond(mulCond),
      .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .roundModeOneHot(roundModeOneHot), .yBus(yBus),
      .cRegOut(cRegOut), .statusOe(statusOe), .roundingIncrementFlag(roundingIncrementFlag),
      .equalOrZeroFlag(equalOrZeroFlag), .aGreaterFlag(aGreaterFlag),
      .chainExceptionFlag(chainExceptionFlag), .tinyResultFlag(tinyResultFlag),
      .tinyOperandMultiplierFlag(tinyOperandMultiplierFlag), .notExactFlag(notExactFlag),
      .zeroDivisorFlag(zeroDivisorFlag), .exceptionSummaryFlag(exceptionSummaryFlag),
      .resultIsUnboundedFlag(resultIsUnboundedFlag), .signFlagMinus(signFlagMinus),
      .invalidOperationFlag(invalidOperationFlag), .exponentTooLargeFlag(exponentTooLargeFlag),
      .exponentTooSmallFlag(exponentTooSmallFlag), .exceptionOriginFlag(exceptionOriginFlag),
      .operandPortFlags(operandPortFlags), .incomparableOperandsFlag(incomparableOperandsFlag));
   always #20 sys_clk = ~sys_clk;
   task check(input logic [63:0] seen, input logic [63:0] exp);
   begin
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
   begin
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge sys_clk);
      regWrStb <= 1'b0;
   end
   endtask
   // Read data stand only in the cycle after the strobe, so sample there
   task rd(input logic [3:0] a, input logic [31:0] exp);
   begin
      @(posedge sys_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge sys_clk);
      regRdStb <= 1'b0;
      @(negedge sys_clk);
      check(regRdData, exp);
   end
   endtask
   task op(input logic [14:0] ac, input logic [14:0] mc, input logic [6:0] ctl,
      input logic [17:0] exp);
   begin
      @(posedge sys_clk);
      u_ctrl.put(ac, mc, ctl);
      @(negedge sys_clk);
      check(flags, exp);
   end
   endtask
   task conclude;
   begin
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      conclude;
   end
   initial
   begin
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(4'h0, 32'h0);
      for (i = 0; i < 4; i++)
      begin
         @(posedge sys_clk);
         roundingModeSelect <= i[1:0];
         rd(4'h2, {30'h0, i[1:0]});
         check(roundModeOneHot, 4'h1 << i);
      end
      @(posedge sys_clk);
      u_ctrl.put(15'h0102, 15'h0000, 7'h00);
      repeat (2) @(posedge sys_clk);
      rd(4'h1, 32'h00000102);
      $display("test registers done");
      for (i = 0; i < 3; i++)
      begin
         @(posedge sys_clk);
         aluMultiplierPipeBypass <= (i > 0);
         resultStageBypass <= (i > 1);
         u_ctrl.put(15'h0000, 15'h0000, 7'h00);
         repeat (3) @(posedge sys_clk);
         u_ctrl.put(15'h0003, 15'h0000, 7'h00);
         for (j = 0; j < 3; j++)
         begin
            @(negedge sys_clk);
            check(zeroDivisorFlag, j == 2 - i);
            @(posedge sys_clk);
            u_ctrl.put(15'h0000, 15'h0000, 7'h00);
         end
      end
      $display("test latency done");
      op(15'h0180, 15'h0000, 7'h00, 18'h00180);
      op(15'h0004, 15'h0000, 7'h00, 18'h00420);
      op(15'h0018, 15'h0000, 7'h00, 18'h00610);
      op(15'h0C00, 15'h0000, 7'h02, 18'h08001);
      op(15'h0200, 15'h0000, 7'h02, 18'h10000);
      op(15'h0000, 15'h0000, 7'h20, 18'h10000);
      op(15'h0000, 15'h4040, 7'h01, 18'h0240C);
      op(15'h1000, 15'h0000, 7'h00, 18'h20000);
      op(15'h0001, 15'h0000, 7'h0C, 18'h04440);
      op(15'h0000, 15'h0002, 7'h09, 18'h04C08);
      op(15'h7FFF, 15'h0000, 7'h10, 18'h00000);
      wr(4'h0, 32'h00000001);
      op(15'h0001, 15'h0000, 7'h0C, 18'h04040);
      op(15'h0004, 15'h0000, 7'h00, 18'h00420);
      $display("test flags done");
      for (i = 0; i < 3; i++)
      begin
         @(posedge sys_clk);
         resultHalfSelect <= (i > 0);
         u_ctrl.put(15'h0000, 15'h0000, {i == 2, 6'h00});
         @(negedge sys_clk);
         check(yBus, i == 1 ? 32'h12345678 : 32'h9ABCDEF0);
      end
      @(posedge sys_clk);
      resultHalfSelect <= 1'b0;
      flushToZeroSelect <= 1'b1;
      u_ctrl.put(15'h0020, 15'h0000, 7'h00);
      @(negedge sys_clk);
      check({tinyResultFlag, yBus}, 33'h100000000);
      @(posedge sys_clk);
      flushToZeroSelect <= 1'b0;
      @(negedge sys_clk);
      check(yBus, 32'h9ABCDEF0);
      for (i = 0; i < 2; i++)
      begin
         @(posedge sys_clk);
         cRegisterSourceSelect <= i[0];
         cRegisterWriteN <= 1'b0;
         @(posedge sys_clk);
         cRegisterWriteN <= 1'b1;
         @(negedge sys_clk);
         check(cRegOut, i ? 64'h0FEDCBA987654321 : 64'h123456789ABCDEF0);
      end
      $display("test data path done");
      @(posedge sys_clk);
      rstn <= 1'b0;
      @(posedge sys_clk);
      rstn <= 1'b1;
      rd(4'h0, 32'h0);
      check(cRegOut, 64'h0FEDCBA987654321);
      $display("test reset done");
      conclude;
   end
endmodule // fpsc_unit_test
bind fpsc_unit fpsc_unit_sva i_sva (.sys_clk(sys_clk), .rstn(rstn),
   .aluMultiplierPipeBypass(aluMultiplierPipeBypass), .resultStageBypass(resultStageBypass),
   .roundingModeSelect(roundingModeSelect), .statusOutputEnableN(statusOutputEnableN),
   .resultFromMultiplier(resultFromMultiplier), .aluCond(aluCond), .mulCond(mulCond),
   .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
   .regRdData(regRdData), .roundModeOneHot(roundModeOneHot), .statusOe(statusOe),
   .zeroDivisorFlag(zeroDivisorFlag), .exceptionSummaryFlag(exceptionSummaryFlag),
   .invalidOperationFlag(invalidOperationFlag), .operandPortFlags(operandPortFlags),
   .tinyOperandMultiplierFlag(tinyOperandMultiplierFlag));
